// ==== core/qpot_pkg.sv ====
// constants and types for the quad pot two-wire slave
package qpot_pkg;
	localparam int CLK_HZ = 10000000;
	localparam int NV_PROGRAM_TIME_MS = 5;
	localparam int NV_PROGRAM_CYCLES = (CLK_HZ / 1000) * NV_PROGRAM_TIME_MS;
	// device type code: arbitrary neutral value
	localparam logic [3:0] DEV_TYPE_CODE = 4'ha;
	localparam logic [3:0] OP_READ_WIPER = 4'h9;
	localparam logic [3:0] OP_WRITE_WIPER = 4'ha;
	localparam logic [3:0] OP_READ_SETTING = 4'hb;
	localparam logic [3:0] OP_WRITE_SETTING = 4'hc;
	localparam logic [3:0] OP_TRANSFER_TO_WIPER = 4'hd;
	localparam logic [3:0] OP_TRANSFER_TO_SETTING = 4'he;
	localparam logic [3:0] OP_ALL_TRANSFER_TO_WIPER = 4'h1;
	localparam logic [3:0] OP_ALL_TRANSFER_TO_SETTING = 4'h8;
	localparam logic [3:0] OP_INC_DEC = 4'h2;
	localparam logic [5:0] WIPER_MAX = 6'h3f;
	localparam logic [5:0] WIPER_MIN = 6'h00;
	localparam logic [5:0] SETTING_RESET = 6'h20;
	localparam logic [3:0] BIT_LAST = 4'h7;
	localparam logic [3:0] BIT_ACK = 4'h8;
	// count before the first bit: the clock fall that follows a start wraps it to zero
	localparam logic [3:0] BIT_PRE = 4'hf;
	typedef enum {ST_IDLE, ST_ADDR, ST_INSTR, ST_DATA, ST_READ, ST_INCDEC, ST_WAIT_STOP} qpot_state_t;
endpackage

// ==== core/qpot_i2c_slave.sv ====
// two-wire slave controller for a quad digital pot with stored settings
`timescale 1ns/1ps

// What this block does
// RQ1 - after a stored-setting write stop, stay off the bus for the program time
// RQ2 - start is data falling with clock high; ignore the bus until one is seen
// RQ3 - stop is data rising with clock high and ends the operation
// RQ4 - data changing while clock is high is taken as start or stop
// RQ5 - master makes every clock; this block only samples the clock line
// RQ6 - master starts a new transfer only while the bus is idle
// RQ7 - first byte is the address: type code high nibble, device select low
// RQ8 - low address nibble must equal the strap pins to go on
// RQ9 - acknowledge a matching address, stay silent otherwise
// RQ10 - acknowledge by pulling data low during the ninth clock
// RQ11 - acknowledge the instruction byte and the data byte of a write
// RQ12 - read sends eight bits, samples ack, continues on ack, else waits stop
// RQ13 - write is address, instruction, data then stop; stop starts programming
// RQ14 - instruction has opcode high nibble, pot select, then setting select
// RQ15 - setting select 00,01,10,11 picks settings zero to three
// RQ16 - while programming withhold address ack, acknowledge once finished
// RQ17 - four 6-bit wiper registers, each decoded to one of 64 taps
// RQ18 - wipers change only by write, transfer, step or power-up recall
// RQ19 - at power-up load each wiper from its stored setting zero
// RQ20 - four 6-bit stored settings per pot, readable, writable, transferable
// RQ21 - any stored-setting change is a nonvolatile operation
// RQ22 - nine opcodes with read and write as three-byte sequences
// RQ23 - after inc/dec ack, each clock steps the wiper up if data high else down
// RQ24 - sample bus lines on the system clock and detect edges from samples
// RQ25 - a counter ends the busy period within the program time
module qpot_i2c_slave
	import qpot_pkg::*;
#(
	parameter int NV_CYCLES = qpot_pkg::NV_PROGRAM_CYCLES
)
(
	// clock and reset
	input wire logic CLK_SYS_IN,
	input wire logic SRST_IN,
	// two-wire bus
	input wire logic SCL_IN,
	input wire logic SDA_IN,
	output logic SDA_OUT,
	output logic SDA_OE_N_OUT,
	// address straps
	input wire logic [3:0] ADDRESS_STRAP_PINS_IN,
	// tap selection, one-hot per pot
	output logic [63:0] TAP_SEL0_OUT,
	output logic [63:0] TAP_SEL1_OUT,
	output logic [63:0] TAP_SEL2_OUT,
	output logic [63:0] TAP_SEL3_OUT,
	// status
	output logic NV_BUSY_OUT
);
	import qpot_pkg::*;

	// ----------------------------------------
	// input synchronisers
	// ----------------------------------------
	logic [2:0] scl_sync_reg, scl_sync_next;
	logic [2:0] sda_sync_reg, sda_sync_next;
	logic scl_reg, scl_next, sda_reg, sda_next;
	logic [3:0] strap_s1_reg, strap_s2_reg, strap_s3_reg, strap_reg, strap_next;

	always_comb
	begin
		scl_sync_next = {scl_sync_reg[1:0], SCL_IN}; // [RQ24]
		sda_sync_next = {sda_sync_reg[1:0], SDA_IN};
		scl_next = (scl_sync_reg[1] == scl_sync_reg[2]) ? scl_sync_reg[2] : scl_reg;
		sda_next = (sda_sync_reg[1] == sda_sync_reg[2]) ? sda_sync_reg[2] : sda_reg;
		strap_next = (strap_s2_reg == strap_s3_reg) ? strap_s3_reg : strap_reg;
	end

	always_ff @(posedge CLK_SYS_IN)
	begin
		if (SRST_IN)
		begin
			scl_sync_reg <= 3'h7;
			sda_sync_reg <= 3'h7;
			scl_reg <= 1'b1;
			sda_reg <= 1'b1;
			strap_s1_reg <= 4'h0;
			strap_s2_reg <= 4'h0;
			strap_s3_reg <= 4'h0;
			strap_reg <= 4'h0;
		end
		else
		begin
			scl_sync_reg <= scl_sync_next;
			sda_sync_reg <= sda_sync_next;
			scl_reg <= scl_next;
			sda_reg <= sda_next;
			strap_s1_reg <= ADDRESS_STRAP_PINS_IN;
			strap_s2_reg <= strap_s1_reg;
			strap_s3_reg <= strap_s2_reg;
			strap_reg <= strap_next;
		end
	end

	logic scl_rise, scl_fall, start_det, stop_det;
	// a data change with clock high is never data, only start or stop
	assign scl_rise = scl_next & ~scl_reg;
	assign scl_fall = ~scl_next & scl_reg;
	assign start_det = scl_reg & scl_next & sda_reg & ~sda_next; // [RQ2] [RQ4]
	assign stop_det = scl_reg & scl_next & ~sda_reg & sda_next; // [RQ3] [RQ4]

	// ----------------------------------------
	// protocol engine and registers
	// ----------------------------------------
	qpot_state_t state_reg, state_next;
	logic [3:0] bit_cnt_reg, bit_cnt_next;
	logic [7:0] shift_reg, shift_next;
	logic [7:0] instr_reg, instr_next;
	logic sda_low_reg, sda_low_next;
	logic nv_pend_reg, nv_pend_next;
	logic [31:0] busy_cnt_reg, busy_cnt_next;
	logic recall_reg, recall_next;
	logic [5:0] wiper_reg [4];
	logic [5:0] wiper_next [4];
	logic [5:0] setting_reg [16];
	logic [5:0] setting_next [16];

	logic [3:0] opcode;
	logic [1:0] pot_sel, set_sel;
	logic busy;
	assign opcode = instr_reg[7:4]; // [RQ14]
	assign pot_sel = instr_reg[3:2];
	assign set_sel = instr_reg[1:0]; // [RQ15]
	assign busy = (busy_cnt_reg != 32'h0);

	always_comb
	begin
		state_next = state_reg;
		bit_cnt_next = bit_cnt_reg;
		shift_next = shift_reg;
		instr_next = instr_reg;
		sda_low_next = sda_low_reg;
		nv_pend_next = nv_pend_reg;
		recall_next = 1'b0;
		busy_cnt_next = busy ? busy_cnt_reg - 32'h1 : busy_cnt_reg; // [RQ25]
		wiper_next = wiper_reg;
		setting_next = setting_reg;
		if (recall_reg)
		begin
			for (int p = 0; p < 4; p++)
				wiper_next[p] = setting_reg[p * 4]; // [RQ19]
		end
		if (stop_det)
		begin
			state_next = ST_IDLE; // [RQ3]
			sda_low_next = 1'b0;
			if (nv_pend_reg)
			begin
				busy_cnt_next = 32'(NV_CYCLES); // [RQ1] [RQ13] [RQ21]
				nv_pend_next = 1'b0;
			end
		end
		else if (start_det)
		begin
			// while programming the bus is ignored, so polls see no ack
			state_next = busy ? ST_IDLE : ST_ADDR; // [RQ1] [RQ16] [RQ2]
			bit_cnt_next = BIT_PRE;
			sda_low_next = 1'b0;
			nv_pend_next = 1'b0;
		end
		else
		begin
			case (state_reg)
				ST_IDLE:
				begin
					sda_low_next = 1'b0;
				end
				ST_ADDR, ST_INSTR, ST_DATA:
				begin
					if (scl_rise && bit_cnt_reg <= BIT_LAST)
						shift_next = {shift_reg[6:0], sda_reg};
					if (scl_fall)
					begin
						if (bit_cnt_reg == BIT_LAST)
						begin
							bit_cnt_next = BIT_ACK;
							if (state_reg == ST_ADDR)
							begin
								// [RQ7] [RQ8] [RQ9]
								if (shift_reg[7:4] == DEV_TYPE_CODE && shift_reg[3:0] == strap_reg)
									sda_low_next = 1'b1; // [RQ10]
								else
									state_next = ST_WAIT_STOP;
							end
							else
								sda_low_next = 1'b1; // [RQ11]
						end
						else if (bit_cnt_reg == BIT_ACK)
						begin
							sda_low_next = 1'b0;
							bit_cnt_next = 4'h0;
							case (state_reg)
								ST_ADDR:
								begin
									state_next = ST_INSTR;
								end
								ST_INSTR:
								begin
									instr_next = shift_reg;
									state_next = ST_DATA; // [RQ22]
									case (shift_reg[7:4])
										// read bytes start with a zero msb, so the line goes low at once
										OP_READ_WIPER:
										begin
											state_next = ST_READ; // [RQ12]
											shift_next = {2'b00, wiper_reg[shift_reg[3:2]]};
											sda_low_next = 1'b1;
										end
										OP_READ_SETTING:
										begin
											state_next = ST_READ; // [RQ12]
											shift_next = {2'b00, setting_reg[shift_reg[3:0]]};
											sda_low_next = 1'b1;
										end
										OP_TRANSFER_TO_WIPER:
										begin
											wiper_next[shift_reg[3:2]] = setting_reg[{shift_reg[3:2], shift_reg[1:0]}]; // [RQ18]
											state_next = ST_WAIT_STOP;
										end
										OP_TRANSFER_TO_SETTING:
										begin
											setting_next[{shift_reg[3:2], shift_reg[1:0]}] = wiper_reg[shift_reg[3:2]]; // [RQ20]
											nv_pend_next = 1'b1;
											state_next = ST_WAIT_STOP;
										end
										OP_ALL_TRANSFER_TO_WIPER:
										begin
											for (int p = 0; p < 4; p++)
												wiper_next[p] = setting_reg[p * 4 + int'(shift_reg[1:0])];
											state_next = ST_WAIT_STOP;
										end
										OP_ALL_TRANSFER_TO_SETTING:
										begin
											for (int p = 0; p < 4; p++)
												setting_next[p * 4 + int'(shift_reg[1:0])] = wiper_reg[p];
											nv_pend_next = 1'b1;
											state_next = ST_WAIT_STOP;
										end
										OP_INC_DEC:
										begin
											state_next = ST_INCDEC; // [RQ23]
										end
										default:
										begin
											state_next = ST_DATA;
										end
									endcase
								end
								default:
								begin
									state_next = ST_WAIT_STOP;
									if (opcode == OP_WRITE_WIPER)
										wiper_next[pot_sel] = shift_reg[5:0]; // [RQ18]
									else if (opcode == OP_WRITE_SETTING)
									begin
										setting_next[{pot_sel, set_sel}] = shift_reg[5:0]; // [RQ20] [RQ21]
										nv_pend_next = 1'b1;
									end
								end
							endcase
						end
						else
							bit_cnt_next = bit_cnt_reg + 4'h1;
					end
				end
				ST_READ:
				begin
					// read returns the selected wiper or stored setting, msbs of the byte are zero
					if (scl_rise && bit_cnt_reg == BIT_ACK && sda_reg)
						state_next = ST_WAIT_STOP; // [RQ12]
					if (scl_fall)
					begin
						if (bit_cnt_reg == BIT_LAST)
						begin
							bit_cnt_next = BIT_ACK;
							sda_low_next = 1'b0; // [RQ12]
						end
						else if (bit_cnt_reg == BIT_ACK)
						begin
							bit_cnt_next = 4'h0;
							if (opcode == OP_READ_SETTING)
								shift_next = {2'b00, setting_reg[{pot_sel, set_sel}]};
							else
								shift_next = {2'b00, wiper_reg[pot_sel]};
							sda_low_next = 1'b1;
						end
						else
						begin
							bit_cnt_next = bit_cnt_reg + 4'h1;
							shift_next = {shift_reg[6:0], 1'b0};
							sda_low_next = ~shift_reg[6];
						end
					end
				end
				ST_INCDEC:
				begin
					if (scl_rise)
					begin
						if (sda_reg && wiper_reg[pot_sel] != WIPER_MAX)
							wiper_next[pot_sel] = wiper_reg[pot_sel] + 6'h01; // [RQ23]
						else if (!sda_reg && wiper_reg[pot_sel] != WIPER_MIN)
							wiper_next[pot_sel] = wiper_reg[pot_sel] - 6'h01; // [RQ23]
					end
				end
				ST_WAIT_STOP:
				begin
					sda_low_next = 1'b0;
				end
				default:
				begin
					state_next = ST_IDLE;
				end
			endcase
		end
	end

	always_ff @(posedge CLK_SYS_IN)
	begin
		if (SRST_IN)
		begin
			state_reg <= ST_IDLE;
			bit_cnt_reg <= 4'h0;
			shift_reg <= 8'h00;
			instr_reg <= 8'h00;
			sda_low_reg <= 1'b0;
			nv_pend_reg <= 1'b0;
			busy_cnt_reg <= 32'h0;
			recall_reg <= 1'b1;
			wiper_reg <= '{default: WIPER_MIN};
			// the model cannot keep settings across reset, they restart here
			setting_reg <= '{default: SETTING_RESET};
		end
		else
		begin
			state_reg <= state_next;
			bit_cnt_reg <= bit_cnt_next;
			shift_reg <= shift_next;
			instr_reg <= instr_next;
			sda_low_reg <= sda_low_next;
			nv_pend_reg <= nv_pend_next;
			busy_cnt_reg <= busy_cnt_next;
			recall_reg <= recall_next;
			wiper_reg <= wiper_next;
			setting_reg <= setting_next;
		end
	end

	// ----------------------------------------
	// outputs
	// ----------------------------------------
	// open drain: only ever drive low, and never drive the clock [RQ5]
	assign SDA_OUT = 1'b0;
	assign SDA_OE_N_OUT = ~sda_low_reg;
	assign NV_BUSY_OUT = busy;

	logic [63:0] tap_sel [4];
	genvar g;
	generate
		for (g = 0; g < 4; g++)
		begin : g_tap
			assign tap_sel[g] = 64'h1 << wiper_reg[g]; // [RQ17]
		end
	endgenerate
	assign TAP_SEL0_OUT = tap_sel[0];
	assign TAP_SEL1_OUT = tap_sel[1];
	assign TAP_SEL2_OUT = tap_sel[2];
	assign TAP_SEL3_OUT = tap_sel[3];
endmodule

// ==== test/qpot_i2c_slave_sva.sv ====
// assertion checker for the quad pot two-wire slave
`timescale 1ns/1ps
module qpot_i2c_slave_sva
	import qpot_pkg::*;
#(
	parameter int NV_CYCLES = 50000
)
(
	// clock and reset
	input wire logic CLK_SYS_IN,
	input wire logic SRST_IN,
	// bus and straps
	input wire logic SCL_IN,
	input wire logic SDA_IN,
	input wire logic SDA_OUT,
	input wire logic SDA_OE_N_OUT,
	input wire logic [3:0] ADDRESS_STRAP_PINS_IN,
	// taps and status
	input wire logic [63:0] TAP_SEL0_OUT,
	input wire logic [63:0] TAP_SEL1_OUT,
	input wire logic [63:0] TAP_SEL2_OUT,
	input wire logic [63:0] TAP_SEL3_OUT,
	input wire logic NV_BUSY_OUT
);
	int busy_cnt_reg;
	int idle_cnt_reg;
	default clocking @(posedge CLK_SYS_IN); endclocking
	default disable iff (SRST_IN);
	// idle count restarts in reset so the recall load is not seen as a stray change
	always_ff @(posedge CLK_SYS_IN)
	begin
		busy_cnt_reg <= (SRST_IN || !NV_BUSY_OUT) ? 0 : busy_cnt_reg + 1;
		idle_cnt_reg <= (SRST_IN || !(SCL_IN && SDA_IN)) ? 0 : idle_cnt_reg + 1;
	end
	property p_drive_low; SDA_OUT == 1'b0; endproperty
	a_drive_low: assert property (p_drive_low) else $error("data line driven high");
	property p_onehot; $onehot(TAP_SEL0_OUT) && $onehot(TAP_SEL1_OUT) && $onehot(TAP_SEL2_OUT)
		&& $onehot(TAP_SEL3_OUT); endproperty
	a_onehot: assert property (p_onehot) else $error("tap select not one-hot");
	property p_busy_max; busy_cnt_reg <= NV_CYCLES; endproperty
	a_busy_max: assert property (p_busy_max) else $error("busy too long");
	property p_busy_len; $fell(NV_BUSY_OUT) |-> busy_cnt_reg >= NV_CYCLES - 1; endproperty
	a_busy_len: assert property (p_busy_len) else $error("busy too short");
	property p_quiet_busy; NV_BUSY_OUT |-> SDA_OE_N_OUT; endproperty
	a_quiet_busy: assert property (p_quiet_busy) else $error("answer while busy");
	property p_oe_scl_low; $changed(SDA_OE_N_OUT) |-> !SCL_IN; endproperty
	a_oe_scl_low: assert property (p_oe_scl_low) else $error("data moved with clock high");
	property p_ack_stands; $fell(SDA_OE_N_OUT) |-> !SDA_OE_N_OUT [*8]; endproperty
	a_ack_stands: assert property (p_ack_stands) else $error("ack too short");
	property p_ack_clock; $fell(SDA_OE_N_OUT) |-> ##[1:40] (SCL_IN && !SDA_OE_N_OUT); endproperty
	a_ack_clock: assert property (p_ack_clock) else $error("ack not held over clock");
	property p_taps_idle; idle_cnt_reg > 20 |-> $stable(TAP_SEL0_OUT) && $stable(TAP_SEL1_OUT)
		&& $stable(TAP_SEL2_OUT) && $stable(TAP_SEL3_OUT); endproperty
	a_taps_idle: assert property (p_taps_idle) else $error("wiper moved on idle bus");
	property p_busy_stop; $rose(NV_BUSY_OUT) |-> SCL_IN && SDA_IN; endproperty
	a_busy_stop: assert property (p_busy_stop) else $error("busy without stop");
	property p_reset_quiet; disable iff (1'b0) SRST_IN |=> SDA_OE_N_OUT && !NV_BUSY_OUT; endproperty
	a_reset_quiet: assert property (p_reset_quiet) else $error("active in reset");
endmodule

// ==== test/qpot_bus_master.sv ====
// two-wire bus master model driving the slave
`timescale 1ns/1ps
module qpot_bus_master
(
	input wire logic clk_in,
	input wire logic sda_in,
	output logic scl_out,
	output logic sda_out
);
	initial
	begin
		scl_out = 1'b1;
		sda_out = 1'b1;
	end
	task automatic wt(input int n);
		repeat (n) @(posedge clk_in);
	endtask
	// called only on an idle bus, after reset or a stop
	task automatic start_cond();
		sda_out <= 1'b1;
		wt(8);
		sda_out <= 1'b0;
		wt(8);
		scl_out <= 1'b0;
		wt(2);
	endtask
	task automatic stop_cond();
		sda_out <= 1'b0;
		wt(8);
		scl_out <= 1'b1;
		wt(8);
		sda_out <= 1'b1;
		wt(8);
	endtask
	// data set up while the clock is low, clock always from this side
	task automatic send_bit(input logic b, output logic seen);
		sda_out <= b;
		wt(8);
		scl_out <= 1'b1;
		wt(8);
		seen = sda_in;
		scl_out <= 1'b0;
		wt(2);
	endtask
	task automatic send_byte(input logic [7:0] d, output logic ack);
		logic s;
		for (int i = 7; i >= 0; i--)
			send_bit(d[i], s);
		send_bit(1'b1, s);
		ack = (s === 1'b0);
	endtask
endmodule

// ==== test/tb_qpot_i2c_slave.sv ====
// self-checking bench for the quad pot two-wire slave
`timescale 1ns/1ps
module tb_qpot_i2c_slave;
	import qpot_pkg::*;
	localparam int NV_CYCLES = 400;
	localparam logic [7:0] ADDR = 8'ha3;
	logic clk;
	logic srst;
	logic [3:0] straps;
	wire scl;
	wire m_sda;
	wire sda;
	logic sda_dut;
	logic oe_n;
	logic busy;
	logic [63:0] tap [4];
	logic [5:0] wip [4];
	logic [5:0] stg [16];
	logic [31:0] rnd;
	int n_fail;
	int n_tests;
	int cyc;
	// pull-up: a released line reads high
	assign sda = m_sda & (oe_n ? 1'b1 : sda_dut);
	qpot_bus_master m (.clk_in(clk), .sda_in(sda), .scl_out(scl), .sda_out(m_sda));
	qpot_i2c_slave #(.NV_CYCLES(NV_CYCLES)) DUT (.CLK_SYS_IN(clk), .SRST_IN(srst), .SCL_IN(scl),
		.SDA_IN(sda), .SDA_OUT(sda_dut), .SDA_OE_N_OUT(oe_n), .ADDRESS_STRAP_PINS_IN(straps),
		.TAP_SEL0_OUT(tap[0]), .TAP_SEL1_OUT(tap[1]), .TAP_SEL2_OUT(tap[2]), .TAP_SEL3_OUT(tap[3]),
		.NV_BUSY_OUT(busy));
	initial
	begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end
	task automatic print_verdict();
		if (n_fail == 0 && n_tests > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	// hang guard, far above the expected run
	always @(posedge clk)
	begin
		cyc <= cyc + 1;
		if (cyc == 60000)
		begin
			n_fail++;
			print_verdict();
		end
	end
	function automatic logic [31:0] xs(input logic [31:0] x);
		x ^= x << 13;
		x ^= x >> 17;
		x ^= x << 5;
		return x;
	endfunction
	task automatic check(input logic [63:0] seen, input logic [63:0] exp);
		n_tests++;
		if (seen !== exp)
		begin
			n_fail++;
			$display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic chk_taps();
		for (int p = 0; p < 4; p++)
			check(tap[p], 64'h1 << wip[p]);
	endtask
	// nb bytes after the address: 1 = instruction only, 2 = instruction and data
	task automatic cmd(input logic [7:0] adr, input logic [7:0] ins, input logic [7:0] dat, input int nb);
		logic a;
		m.start_cond();
		m.send_byte(adr, a);
		check(a, adr == ADDR);
		if (a && nb > 0)
		begin
			m.send_byte(ins, a);
			check(a, 1'b1);
		end
		if (a && nb > 1)
		begin
			m.send_byte(dat, a);
			check(a, 1'b1);
		end
		m.stop_cond();
	endtask
	task automatic poll();
		logic a;
		check(busy, 1'b1);
		a = 1'b0;
		for (int k = 0; k < 20 && !a; k++)
		begin
			m.start_cond();
			m.send_byte(ADDR, a);
			m.stop_cond();
			if (k == 0)
				check(a, 1'b0);
		end
		check(a, 1'b1);
		check(busy, 1'b0);
	endtask
	// two bytes: acknowledge the first, leave the second unacknowledged
	task automatic rd(input logic [7:0] ins, input logic [5:0] exp);
		logic a;
		logic s;
		logic [7:0] v;
		m.start_cond();
		m.send_byte(ADDR, a);
		m.send_byte(ins, a);
		check(a, 1'b1);
		for (int j = 0; j < 2; j++)
		begin
			for (int i = 7; i >= 0; i--)
			begin
				m.send_bit(1'b1, s);
				v[i] = s;
			end
			m.send_bit(j == 1, s);
			check(v, {2'b00, exp});
		end
		m.stop_cond();
	endtask
	task automatic wr_all();
		for (int p = 0; p < 4; p++)
		begin
			rnd = xs(rnd);
			wip[p] = rnd[5:0];
			cmd(ADDR, {OP_WRITE_WIPER, 2'(p), 2'b00}, {2'b00, rnd[5:0]}, 2);
		end
		chk_taps();
	endtask
	initial
	begin
		logic s;
		rnd = 32'h3;
		srst <= 1'b1;
		straps <= 4'h3;
		foreach (wip[i]) wip[i] = 6'h20;
		foreach (stg[i]) stg[i] = 6'h20;
		repeat (12) @(posedge clk);
		srst <= 1'b0;
		m.wt(8);
		chk_taps();
		wr_all();
		// every setting select of pot 1: store, poll, recall into the wiper
		for (int r = 0; r < 4; r++)
		begin
			rnd = xs(rnd);
			stg[4 + r] = rnd[5:0];
			cmd(ADDR, {OP_WRITE_SETTING, 2'b01, 2'(r)}, {2'b00, rnd[5:0]}, 2);
			poll();
			cmd(ADDR, {OP_TRANSFER_TO_WIPER, 2'b01, 2'(r)}, 8'h00, 1);
			wip[1] = stg[4 + r];
			chk_taps();
		end
		cmd(ADDR, {OP_ALL_TRANSFER_TO_SETTING, 4'b0010}, 8'h00, 1);
		poll();
		for (int p = 0; p < 4; p++)
			stg[p * 4 + 2] = wip[p];
		cmd(ADDR, {OP_TRANSFER_TO_SETTING, 4'b1111}, 8'h00, 1);
		poll();
		stg[15] = wip[3];
		wr_all();
		cmd(ADDR, {OP_ALL_TRANSFER_TO_WIPER, 4'b0010}, 8'h00, 1);
		for (int p = 0; p < 4; p++)
			wip[p] = stg[p * 4 + 2];
		cmd(ADDR, {OP_TRANSFER_TO_WIPER, 4'b1111}, 8'h00, 1);
		wip[3] = stg[15];
		chk_taps();
		// reads, a foreign address and a foreign type code leave the wipers alone
		rd({OP_READ_WIPER, 4'b1100}, wip[3]);
		rd({OP_READ_SETTING, 4'b0110}, stg[6]);
		cmd(ADDR ^ 8'h02, {OP_WRITE_WIPER, 4'h0}, 8'h01, 2);
		cmd(ADDR ^ 8'h80, {OP_WRITE_WIPER, 4'h0}, 8'h01, 2);
		chk_taps();
		// step pot 2 from 2: up once, down five, saturating at the low end
		wip[2] = 6'h02;
		cmd(ADDR, {OP_WRITE_WIPER, 4'b1000}, 8'h02, 2);
		cmd(ADDR, {OP_INC_DEC, 4'b1000}, 8'h00, 1);
		m.start_cond();
		m.send_byte(ADDR, s);
		m.send_byte({OP_INC_DEC, 4'b1000}, s);
		m.send_bit(1'b1, s);
		for (int i = 0; i < 5; i++)
			m.send_bit(1'b0, s);
		m.stop_cond();
		wip[2] = 6'h00;
		chk_taps();
		print_verdict();
	end
endmodule
bind qpot_i2c_slave qpot_i2c_slave_sva #(.NV_CYCLES(NV_CYCLES)) u_sva (.CLK_SYS_IN(CLK_SYS_IN),
	.SRST_IN(SRST_IN), .SCL_IN(SCL_IN), .SDA_IN(SDA_IN), .SDA_OUT(SDA_OUT), .SDA_OE_N_OUT(SDA_OE_N_OUT),
	.ADDRESS_STRAP_PINS_IN(ADDRESS_STRAP_PINS_IN), .TAP_SEL0_OUT(TAP_SEL0_OUT), .TAP_SEL1_OUT(TAP_SEL1_OUT),
	.TAP_SEL2_OUT(TAP_SEL2_OUT), .TAP_SEL3_OUT(TAP_SEL3_OUT), .NV_BUSY_OUT(NV_BUSY_OUT));
